/* verilog/exc_pkg.sv */
/*
 * Shared constants of the exception logging and signalling unit:
 * register offsets, exception identifiers, control bit positions,
 * reset values and timing figures.
 * Assumes a 25 MHz APB clock and 32-bit APB data.
 */
package exc_pkg;

   // clock and bus
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int LOG_W = 14;
   localparam int SEL_W = 4;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_LOG = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_SUMMARY = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_PMON_CTL = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_PMON_CNT = 8'h18;

   // exception identifiers (bit positions in the log)
   localparam int ID_ECC_FATAL = 0;
   localparam int ID_PIN_FATAL = 1;
   localparam int ID_CREDIT_FATAL = 2;
   localparam int ID_PWR_FATAL = 3;
   localparam int ID_TIMEOUT_FATAL = 4;
   localparam int ID_ILLOP_FATAL = 5;
   localparam int ID_POISON_FATAL = 6;
   localparam int ID_PIN_UNCORR = 8;
   localparam int ID_RSPFAIL_UNCORR = 9;
   localparam int ID_SCRPAR_UNCORR = 10;
   localparam int ID_MISALIGNED_REQUEST_EVENT = 11;
   localparam int ID_ECC_CORR = 13;

   // groups of log bits; ids 7 and 12 stay out of every mask
   localparam logic [LOG_W-1:0] LOG_FATAL_MASK = 14'h007F;
   localparam logic [LOG_W-1:0] LOG_UNCORR_MASK = 14'h0F00;
   localparam logic [LOG_W-1:0] LOG_CORR_MASK = 14'h2000;
   localparam logic [LOG_W-1:0] LOG_VALID_MASK = 14'h2F7F;

   // control register bits
   localparam int CTRL_POISON_MODE = 0;
   localparam int CTRL_VIRAL_MODE = 1;
   localparam int CTRL_REMOTE_PIN = 2;
   localparam int CTRL_LOCAL_INTERRUPT_CONTROLLER_EN = 3;
   localparam int CTRL_LOCAL_INTERRUPT_LINE_ONE_MASK = 4;
   localparam int CTRL_NMI_PIN_EN = 5;
   localparam int CTRL_W = 6;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h28;

   // status register bits
   localparam int STAT_VIRAL = 0;
   localparam int STAT_NMI_PEND = 1;
   localparam int STAT_REQ_BUSY = 2;

   // performance counter control fields
   localparam int PMON_EN = 0;
   localparam int PMON_SEL_LSB = 4;

   // default request timeout, in nanoseconds
   localparam int unsigned REQ_TIMEOUT_NS = 1000000;
   localparam int TMO_W = 32;

endpackage

/* verilog/exc_unit.sv */
/*
 * Exception logging and signalling unit: sticky exception log,
 * local sideband and remote packet/pin signalling, NMI gating,
 * bank summary, poison handling, viral state and one event counter.
 * Assumes an APB master on pclk, event inputs from logic on pclk,
 * and the two error pins plus the NMI pin arriving asynchronously.
 */
`timescale 1ns/1ps

module exc_unit
   import exc_pkg::*;
#(
   parameter int unsigned TMO_CYCLES =
      (REQ_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic uncorrectable_ecc_event,
   input wire logic ecc_addr_known,
   input wire logic correctable_ecc_event,
   input wire logic credit_error_event,
   input wire logic power_unit_fatal_event,
   input wire logic scratch_parity_event,
   input wire logic misaligned_request_event,
   input wire logic fatal_pin_input,
   input wire logic uncorrected_pin_input,
   input wire logic req_issue,
   input wire logic completion_response,
   input wire logic rsp_in_valid,
   input wire logic rsp_in_fail,
   input wire logic pkt_valid,
   input wire logic pkt_opcode_legal,
   input wire logic pkt_poison,
   input wire logic pkt_final_consumer,
   input wire logic pkt_noncoherent_standard_class,
   input wire logic pkt_noncoherent_bypass_class,
   input wire logic pkt_viral,
   input wire logic platform_fatal_tree_irq,
   input wire logic core_internal_error,
   input wire logic core_machine_check_error,
   input wire logic [2:0] other_bank_flags,
   input wire logic nmi_pin,
   input wire logic virtual_wire_message_nmi,
   input wire logic wait_for_startup_state,
   input wire logic out_rsp_valid,
   output logic [LOG_W-1:0] sideband_events,
   output logic remote_error_packet,
   output logic uncorrected_error_out_pin,
   output logic fatal_error_out_pin,
   output logic core_irq,
   output logic nmi_take,
   output logic poison_forward,
   output logic poison_packet_emit,
   output logic rsp_out_valid,
   output logic rsp_out_viral,
   output logic viral_state_flag
);

   // register state
   logic [LOG_W-1:0] log_reg, log_next;
   logic [LOG_W-1:0] irq_en_reg;
   logic [CTRL_W-1:0] ctrl_reg;
   logic [3:0] summary_reg;
   logic [7:0] pmon_ctl_reg;
   logic [DATA_W-1:0] pmon_cnt_reg, pmon_cnt_next;
   logic viral_reg;
   logic nmi_pend_reg;
   logic req_busy_reg;
   logic [TMO_W-1:0] tmo_cnt_reg;
   logic [DATA_W-1:0] prdata_reg;
   logic pready_reg, pslverr_reg;

   // synchronisers for asynchronous pins
   logic [1:0] fpin_sync_reg, upin_sync_reg, nmi_sync_reg;
   logic fpin_d_reg, upin_d_reg, nmi_d_reg;

   // output flops
   logic [LOG_W-1:0] sideband_reg;
   logic remote_pkt_reg, upin_out_reg, fpin_out_reg, core_irq_reg;
   logic nmi_take_reg, poison_fwd_reg, poison_emit_reg;
   logic rsp_valid_reg, rsp_viral_reg;

   // bus decode
   wire bus_setup = psel & ~penable;
   wire bus_done = psel & penable & pready_reg;
   wire wr_en = bus_done & pwrite;
   wire hit_log = (paddr == OFF_LOG);
   wire hit_irq = (paddr == OFF_IRQ_EN);
   wire hit_ctrl = (paddr == OFF_CTRL);
   wire hit_stat = (paddr == OFF_STATUS);
   wire hit_sum = (paddr == OFF_SUMMARY);
   wire hit_pctl = (paddr == OFF_PMON_CTL);
   wire hit_pcnt = (paddr == OFF_PMON_CNT);
   wire hit_any = hit_log | hit_irq | hit_ctrl | hit_stat | hit_sum |
      hit_pctl | hit_pcnt;

   // control fields
   wire poison_mode = ctrl_reg[CTRL_POISON_MODE];
   wire viral_mode = ctrl_reg[CTRL_VIRAL_MODE];
   wire remote_via_pin = ctrl_reg[CTRL_REMOTE_PIN];
   wire local_interrupt_controller_en = ctrl_reg[CTRL_LOCAL_INTERRUPT_CONTROLLER_EN];
   wire local_interrupt_line_one_mask = ctrl_reg[CTRL_LOCAL_INTERRUPT_LINE_ONE_MASK];
   wire nmi_pin_en = ctrl_reg[CTRL_NMI_PIN_EN];

   // pin edges, read only from the second synchroniser stage onward
   wire fpin_rise = fpin_sync_reg[1] & ~fpin_d_reg;
   wire upin_rise = upin_sync_reg[1] & ~upin_d_reg;
   wire nmi_rise = nmi_sync_reg[1] & ~nmi_d_reg;

   // packet classification
   wire pkt_nc = pkt_noncoherent_standard_class |
      pkt_noncoherent_bypass_class;
   wire illegal_opcode_event = pkt_valid & ~pkt_opcode_legal;
   wire poison_consumed = pkt_valid & pkt_poison & pkt_final_consumer;
   wire poison_passing = pkt_valid & pkt_poison & ~pkt_final_consumer;
   wire response_fail_event = rsp_in_valid & rsp_in_fail;
   wire tmo_hit = req_busy_reg & ~completion_response &
      (tmo_cnt_reg == TMO_W'(TMO_CYCLES - 1));

   // exception vector by identifier; reserved ids tied low
   logic [LOG_W-1:0] ev;
   assign ev[ID_ECC_FATAL] = uncorrectable_ecc_event;
   assign ev[ID_PIN_FATAL] = fpin_rise;
   assign ev[ID_CREDIT_FATAL] = credit_error_event;
   assign ev[ID_PWR_FATAL] = power_unit_fatal_event;
   assign ev[ID_TIMEOUT_FATAL] = tmo_hit;
   assign ev[ID_ILLOP_FATAL] = illegal_opcode_event;
   assign ev[ID_POISON_FATAL] = poison_consumed;
   assign ev[7] = 1'b0;
   assign ev[ID_PIN_UNCORR] = upin_rise;
   assign ev[ID_RSPFAIL_UNCORR] = response_fail_event;
   assign ev[ID_SCRPAR_UNCORR] = scratch_parity_event;
   assign ev[ID_MISALIGNED_REQUEST_EVENT] = misaligned_request_event;
   assign ev[12] = 1'b0;
   assign ev[ID_ECC_CORR] = correctable_ecc_event;

   // sticky log: a new event beats a same-cycle clear
   wire [LOG_W-1:0] log_clr = (wr_en & hit_log) ?
      pwdata[LOG_W-1:0] : {LOG_W{1'b0}};
   assign log_next = ((log_reg & ~log_clr) | ev) &
      LOG_VALID_MASK;

   // uncorrected errors count as fatal unless poison mode splits them
   wire [LOG_W-1:0] fatal_grp = poison_mode ? LOG_FATAL_MASK :
      (LOG_FATAL_MASK | LOG_UNCORR_MASK);
   wire [LOG_W-1:0] uncorr_grp = poison_mode ? LOG_UNCORR_MASK :
      {LOG_W{1'b0}};
   wire fatal_any = |(log_next & fatal_grp);
   wire uncorr_any = |(log_next & uncorr_grp);
   wire remote_new = |(ev & (LOG_FATAL_MASK | LOG_UNCORR_MASK));

   // viral entry sources
   wire viral_explicit = pkt_valid & pkt_nc & pkt_viral;
   wire viral_implicit = pkt_valid & pkt_nc &
      (illegal_opcode_event | poison_consumed);
   wire viral_set = viral_explicit | viral_implicit |
      platform_fatal_tree_irq | core_internal_error |
      core_machine_check_error;

   // nmi gating
   wire vlw_accept = virtual_wire_message_nmi & ~local_interrupt_line_one_mask &
      local_interrupt_controller_en;
   wire nmi_req = (nmi_rise & nmi_pin_en) | vlw_accept;
   wire nmi_fire = (nmi_req | nmi_pend_reg) &
      ~wait_for_startup_state;

   // performance counter counts the selected exception id
   wire [SEL_W-1:0] pmon_sel = pmon_ctl_reg[PMON_SEL_LSB +: SEL_W];
   wire pmon_hit = pmon_ctl_reg[PMON_EN] &
      (pmon_sel < SEL_W'(LOG_W)) & ev[pmon_sel];
   assign pmon_cnt_next = (wr_en & hit_pcnt) ? pwdata :
      (pmon_hit ? pmon_cnt_reg + 32'h0000_0001 : pmon_cnt_reg);

   // read mux
   logic [DATA_W-1:0] rd_mux;
   always_comb begin
      rd_mux = {DATA_W{1'b0}};
      case (1'b1)
         hit_log: rd_mux[LOG_W-1:0] = log_reg;
         hit_irq: rd_mux[LOG_W-1:0] = irq_en_reg;
         hit_ctrl: rd_mux[CTRL_W-1:0] = ctrl_reg;
         hit_stat: begin
            rd_mux[STAT_VIRAL] = viral_reg;
            rd_mux[STAT_NMI_PEND] = nmi_pend_reg;
            rd_mux[STAT_REQ_BUSY] = req_busy_reg;
         end
         hit_sum: rd_mux[3:0] = summary_reg;
         hit_pctl: rd_mux[7:0] = pmon_ctl_reg;
         hit_pcnt: rd_mux = pmon_cnt_reg;
         default: rd_mux = {DATA_W{1'b0}};
      endcase
   end

   // apb answer: one access cycle, data latched at setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= bus_setup;
         pslverr_reg <= bus_setup & ~hit_any;
         if (bus_setup) begin
            prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
         end
      end
   end

   // software-written configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_en_reg <= 14'h0000;
         ctrl_reg <= CTRL_RESET;
         pmon_ctl_reg <= 8'h00;
      end else if (wr_en) begin
         if (hit_irq) begin
            irq_en_reg <= pwdata[LOG_W-1:0] & LOG_VALID_MASK;
         end
         if (hit_ctrl) begin
            ctrl_reg <= pwdata[CTRL_W-1:0];
         end
         if (hit_pctl) begin
            pmon_ctl_reg <= pwdata[7:0];
         end
      end
   end

   // log, counter and summary
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         log_reg <= 14'h0000;
         pmon_cnt_reg <= 32'h0000_0000;
         summary_reg <= 4'h0;
      end else begin
         log_reg <= log_next;
         pmon_cnt_reg <= pmon_cnt_next;
         summary_reg <= {other_bank_flags, |log_next};
      end
   end

   // pin synchronisers and edge history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fpin_sync_reg <= 2'h0;
         upin_sync_reg <= 2'h0;
         nmi_sync_reg <= 2'h0;
         fpin_d_reg <= 1'b0;
         upin_d_reg <= 1'b0;
         nmi_d_reg <= 1'b0;
      end else begin
         fpin_sync_reg <= {fpin_sync_reg[0], fatal_pin_input};
         upin_sync_reg <= {upin_sync_reg[0], uncorrected_pin_input};
         nmi_sync_reg <= {nmi_sync_reg[0], nmi_pin};
         fpin_d_reg <= fpin_sync_reg[1];
         upin_d_reg <= upin_sync_reg[1];
         nmi_d_reg <= nmi_sync_reg[1];
      end
   end

   // single outstanding request watchdog; a new issue restarts it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_busy_reg <= 1'b0;
         tmo_cnt_reg <= 32'h0000_0000;
      end else if (req_issue) begin
         req_busy_reg <= 1'b1;
         tmo_cnt_reg <= 32'h0000_0000;
      end else if (completion_response | tmo_hit) begin
         req_busy_reg <= 1'b0;
      end else if (req_busy_reg) begin
         tmo_cnt_reg <= tmo_cnt_reg + 32'h0000_0001;
      end
   end

   // viral state: only reset leaves it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         viral_reg <= 1'b0;
      end else if (viral_set) begin
         viral_reg <= 1'b1;
      end
   end

   // nmi pending while the thread waits for startup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nmi_pend_reg <= 1'b0;
         nmi_take_reg <= 1'b0;
      end else begin
         nmi_take_reg <= nmi_fire;
         nmi_pend_reg <= (nmi_pend_reg | nmi_req) &
            wait_for_startup_state;
      end
   end

   // signalling outputs, all registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sideband_reg <= 14'h0000;
         remote_pkt_reg <= 1'b0;
         upin_out_reg <= 1'b0;
         fpin_out_reg <= 1'b0;
         core_irq_reg <= 1'b0;
      end else begin
         sideband_reg <= ev;
         remote_pkt_reg <= remote_new & ~remote_via_pin;
         upin_out_reg <= remote_via_pin & uncorr_any;
         fpin_out_reg <= remote_via_pin & fatal_any;
         core_irq_reg <= |(log_next & irq_en_reg);
      end
   end

   // poison and response marking; the triggering response is covered
   // because the same-cycle entry is folded in before the flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         poison_fwd_reg <= 1'b0;
         poison_emit_reg <= 1'b0;
         rsp_valid_reg <= 1'b0;
         rsp_viral_reg <= 1'b0;
      end else begin
         poison_fwd_reg <= poison_passing;
         poison_emit_reg <= poison_mode & uncorrectable_ecc_event &
            ecc_addr_known;
         rsp_valid_reg <= out_rsp_valid;
         rsp_viral_reg <= out_rsp_valid & viral_mode &
            (viral_reg | viral_set);
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign sideband_events = sideband_reg;
   assign remote_error_packet = remote_pkt_reg;
   assign uncorrected_error_out_pin = upin_out_reg;
   assign fatal_error_out_pin = fpin_out_reg;
   assign core_irq = core_irq_reg;
   assign nmi_take = nmi_take_reg;
   assign poison_forward = poison_fwd_reg;
   assign poison_packet_emit = poison_emit_reg;
   assign rsp_out_valid = rsp_valid_reg;
   assign rsp_out_viral = rsp_viral_reg;
   assign viral_state_flag = viral_reg;

endmodule

/* tb/exc_unit_assertions.sv */
/* Concurrent checks on the exception unit ports.
   Assumes binding to exc_unit, one clock pclk, async reset presetn. */
`timescale 1ns/1ps
module exc_unit_assertions
   import exc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic credit_error_event,
   input wire logic pkt_valid,
   input wire logic pkt_opcode_legal,
   input wire logic pkt_poison,
   input wire logic pkt_final_consumer,
   input wire logic pkt_noncoherent_standard_class,
   input wire logic pkt_noncoherent_bypass_class,
   input wire logic pkt_viral,
   input wire logic platform_fatal_tree_irq,
   input wire logic core_internal_error,
   input wire logic core_machine_check_error,
   input wire logic out_rsp_valid,
   input wire logic [LOG_W-1:0] sideband_events,
   input wire logic poison_forward,
   input wire logic rsp_out_valid,
   input wire logic rsp_out_viral,
   input wire logic viral_state_flag
);
   // one domain, so clock and reset are given once
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   reserved_ids_a: assert property (
      !sideband_events[7] && !sideband_events[12])
      else $error("reserved id on sideband");
   credit_logged_a: assert property (
      credit_error_event |=> sideband_events[ID_CREDIT_FATAL])
      else $error("credit error not signalled");
   illegal_op_a: assert property (
      pkt_valid && !pkt_opcode_legal |=> sideband_events[ID_ILLOP_FATAL])
      else $error("illegal opcode not signalled");
   poison_pass_a: assert property (
      pkt_valid && pkt_poison && !pkt_final_consumer |=> poison_forward)
      else $error("poison not passed on");
   viral_explicit_a: assert property (
      pkt_valid && pkt_viral && (pkt_noncoherent_standard_class ||
      pkt_noncoherent_bypass_class) |=> viral_state_flag)
      else $error("viral packet ignored");
   viral_internal_a: assert property (
      platform_fatal_tree_irq || core_internal_error ||
      core_machine_check_error |=> viral_state_flag)
      else $error("internal viral source ignored");
   viral_sticky_a: assert property (
      $rose(viral_state_flag) |=> viral_state_flag [*8])
      else $error("viral state dropped");
   viral_mark_a: assert property (
      out_rsp_valid |=> rsp_out_valid && (!rsp_out_viral || viral_state_flag))
      else $error("response marking wrong");
endmodule

bind exc_unit exc_unit_assertions chk_i (.*);

/* tb/link_agent.sv */
/* Interconnect agent: issues one request on go, then answers with a
   completion after lat cycles. Assumes the pclk domain. */
`timescale 1ns/1ps
module link_agent (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic go,
   input wire logic [7:0] lat,
   output logic req_issue,
   output logic completion_response
);
   logic [7:0] cnt_reg;

   // a slow answer lets the watchdog of the unit expire
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 8'h00;
         req_issue <= 1'b0;
         completion_response <= 1'b0;
      end else begin
         req_issue <= go;
         completion_response <= (cnt_reg == 8'h01);
         cnt_reg <= go ? lat : cnt_reg - {7'h00, cnt_reg != 8'h00};
      end
   end
endmodule

/* tb/uncore_exception_logging_signaling_test.sv */
/* Self-checking bench of the exception unit over APB.
   Assumes exc_pkg, exc_unit and link_agent are compiled first. */
`timescale 1ns/1ps
module uncore_exception_logging_signaling_test
   import exc_pkg::*;
;
   int errors, cmp_count, nmi_cnt, pf_cnt, pe_cnt, rp_cnt, id, e, r;
   int ids[11] = '{0, 1, 2, 3, 5, 6, 8, 9, 10, 11, 13};
   logic [31:0] seed, q, ie, pwdata, prdata;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sl, f, u;
   logic [7:0] paddr, lat;
   logic [10:0] ev;
   logic [4:0] vs;
   logic pfw, go, ecc_addr_known, nmi_pin, virtual_wire_message_nmi;
   logic wait_for_startup_state, out_rsp_valid, req_issue;
   logic completion_response, remote_error_packet, core_irq, nmi_take;
   logic [2:0] other_bank_flags;
   logic [LOG_W-1:0] sideband_events;
   logic uncorrected_error_out_pin, fatal_error_out_pin, poison_forward;
   logic poison_packet_emit, rsp_out_valid, rsp_out_viral, viral_state_flag;
   // event and packet inputs decoded from the stimulus vectors
   wire uncorrectable_ecc_event = ev[0], fatal_pin_input = ev[1];
   wire credit_error_event = ev[2], power_unit_fatal_event = ev[3];
   wire pkt_valid = ev[4] | ev[5] | pfw | vs[0] | vs[1];
   wire pkt_opcode_legal = !ev[4], pkt_poison = ev[5] | pfw;
   wire pkt_final_consumer = ev[5], uncorrected_pin_input = ev[6];
   wire rsp_in_valid = ev[7], rsp_in_fail = ev[7];
   wire scratch_parity_event = ev[8], misaligned_request_event = ev[9];
   wire correctable_ecc_event = ev[10], pkt_viral = vs[0] | vs[1];
   wire pkt_noncoherent_standard_class = vs[0];
   wire pkt_noncoherent_bypass_class = vs[1];
   wire platform_fatal_tree_irq = vs[2], core_internal_error = vs[3];
   wire core_machine_check_error = vs[4];

   // short watchdog keeps the timeout case quick
   exc_unit #(.TMO_CYCLES(16)) dut (.*);
   link_agent agent (.pclk(pclk), .presetn(presetn), .go(go), .lat(lat),
      .req_issue(req_issue), .completion_response(completion_response));

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   // pulse counters on the falling edge, away from the drive edge
   always @(negedge pclk) begin
      nmi_cnt += int'(nmi_take === 1'b1);
      pf_cnt += int'(poison_forward === 1'b1);
      pe_cnt += int'(poison_packet_emit === 1'b1);
      rp_cnt += int'(remote_error_packet === 1'b1);
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h, want %h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // one apb transfer; waits for pready under a bound
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int n;
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         errors++;
         conclude();
      end
      q = prdata;
      sl = pslverr;
      {psel, penable} <= 2'h0;
   endtask

   task automatic rst();
      presetn <= 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
   endtask

   task automatic pulse(input logic [10:0] v, input int n);
      ev <= v;
      repeat (n) @(posedge pclk);
      ev <= '0;
      repeat (4) @(posedge pclk);
   endtask

   task automatic rsp(input logic exp);
      @(posedge pclk);
      out_rsp_valid <= 1'b1;
      @(posedge pclk);
      out_rsp_valid <= 1'b0;
      @(negedge pclk);
      chk(rsp_out_valid, 1'b1);
      chk(rsp_out_viral, exp);
   endtask

   initial begin
      {psel, penable, pwrite, go, pfw, nmi_pin, presetn} = '0;
      {virtual_wire_message_nmi, wait_for_startup_state, out_rsp_valid} = '0;
      {ev, vs, paddr, pwdata, lat, other_bank_flags, ecc_addr_known} = '0;
      seed = 32'h60A6;
      rst();
      apb(0, OFF_SUMMARY, 0);
      chk(q, 0);
      apb(0, OFF_CTRL, 0);
      chk(q, 32'h28);
      seed = lfsr(seed);
      other_bank_flags <= seed[2:0];
      apb(0, OFF_SUMMARY, 0);
      chk(q, {seed[2:0], 1'b0});
      apb(0, 8'h1C, 0);
      chk({sl, q}, 33'h100000000);
      // each event on its own log bit; pins, then packets, both poison modes
      for (int pm = 0; pm < 4; pm++) begin
         apb(1, OFF_CTRL, (pm < 2 ? 32'h2C : 32'h28) | (pm & 1));
         for (int k = 0; k < 11; k++) begin
            id = ids[k];
            seed = lfsr(seed);
            ie = seed & 32'h2F7F;
            e = pe_cnt;
            r = rp_cnt;
            ecc_addr_known <= seed[20];
            apb(1, OFF_IRQ_EN, ie);
            pulse(11'h1 << k, (k == 1 || k == 6) ? 4 : 1);
            apb(0, OFF_LOG, 0);
            f = pm < 2 && (id < 7 || (id > 7 && id < 12 && pm == 0));
            u = id > 7 && id < 12 && pm == 1;
            chk(q, 32'h1 << id);
            chk(core_irq, ie[id]);
            chk(fatal_error_out_pin, f);
            chk(uncorrected_error_out_pin, u);
            chk(rp_cnt - r, pm > 1 && id != 13);
            chk(pe_cnt - e, k == 0 && pm % 2 == 1 && seed[20]);
            apb(1, OFF_LOG, 32'h1 << id);
            apb(0, OFF_LOG, 0);
            chk(q, 0);
         end
      end
      // prompt then late completion of an outgoing request
      for (int s = 0; s < 2; s++) begin
         lat <= s ? 8'h1E : 8'h05;
         go <= 1'b1;
         @(posedge pclk);
         go <= 1'b0;
         repeat (40) @(posedge pclk);
         apb(0, OFF_LOG, 0);
         chk(q, s << 4);
         apb(1, OFF_LOG, 32'h10);
      end
      // pin nmi pends while the thread waits for startup
      {wait_for_startup_state, nmi_pin} <= 2'h3;
      repeat (10) @(posedge pclk);
      chk(nmi_cnt, 0);
      {wait_for_startup_state, nmi_pin} <= 2'h0;
      repeat (6) @(posedge pclk);
      chk(nmi_cnt, 1);
      // virtual wire nmi: masked line, controller off, then accepted
      for (int c = 0; c < 3; c++) begin
         e = nmi_cnt;
         apb(1, OFF_CTRL, c == 0 ? 32'h38 : (c == 1 ? 32'h20 : 32'h28));
         virtual_wire_message_nmi <= 1'b1;
         @(posedge pclk);
         virtual_wire_message_nmi <= 1'b0;
         repeat (6) @(posedge pclk);
         chk(nmi_cnt - e, c == 2);
      end
      // poisoned packet meant for another consumer
      e = pf_cnt;
      pfw <= 1'b1;
      @(posedge pclk);
      pfw <= 1'b0;
      apb(0, OFF_LOG, 0);
      chk({pf_cnt - e, q}, 64'h100000000);
      // every viral source but the implicit one (illegal or poisoned noncoherent packet), each cleared by a reset
      for (int v = 0; v < 5; v++) begin
         apb(1, OFF_CTRL, 32'h2A);
         rsp(0);
         vs <= 5'h01 << v;
         @(posedge pclk);
         vs <= 5'h00;
         rsp(1);
         apb(0, OFF_STATUS, 0);
         chk(q[STAT_VIRAL], 1);
         rst();
         @(posedge pclk);
         chk(viral_state_flag, 0);
      end
      // the single counter follows correctable events
      apb(1, OFF_PMON_CTL, 32'hD1);
      apb(1, OFF_PMON_CNT, 0);
      repeat (3) pulse(11'h400, 1);
      apb(0, OFF_PMON_CNT, 0);
      chk(q, 3);
      apb(0, OFF_PMON_CTL, 0);
      chk(q, 32'hD1);
      conclude();
   end
endmodule
